// ### core/rsc_top.sv
// Reset cause register, watchdog service decoder and reset request with APB slave
`timescale 1ns/1ps
module rsc_top #(
	parameter int RESET_HOLD_CYCLES = rsc_pkg::RESET_HOLD
) (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [rsc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       powerOnDetect,
	input  wire logic                       lowVoltDetect,
	input  wire logic                       referenceLost,
	input  wire logic                       extResetN,
	input  wire logic                       wdTimeout,
	input  wire logic                       illegalOpcode,
	input  wire logic                       haltInstr,
	input  wire logic                       bgndInstr,
	input  wire logic                       illegalAddress,
	output logic                            mcuResetReq,
	output logic                            wdRestart
);
	localparam logic [rsc_pkg::HOLD_W-1:0] HOLD = rsc_pkg::HOLD_W'(RESET_HOLD_CYCLES);

	rsc_cause_if cif ();

	rsc_cause_capture u_capture (
		.clk  (clk),
		.srst (srst),
		.cif  (cif.cap)
	);

	function automatic rsc_pkg::rsc_sel_t rscDecode(input logic [rsc_pkg::ADDR_W-1:0] a);
		case (a)
			rsc_pkg::OFS_CAUSE: rscDecode = rsc_pkg::SEL_CAUSE;
			rsc_pkg::OFS_CTRL:  rscDecode = rsc_pkg::SEL_CTRL;
			rsc_pkg::OFS_DBG:   rscDecode = rsc_pkg::SEL_DBG;
			default:            rscDecode = rsc_pkg::SEL_NONE;
		endcase
	endfunction : rscDecode

	// Level sources from pins and analog detectors
	logic [rsc_pkg::NLVL-1:0] lvlRaw;
	logic [rsc_pkg::NLVL-1:0] lvlSync;

	assign lvlRaw = {powerOnDetect, lowVoltDetect, referenceLost, ~extResetN};

	genvar gi;
	generate
		for (gi = 0; gi < rsc_pkg::NLVL; gi++) begin : g_sync
			logic meta;
			logic sync;
			always_ff @(posedge clk) begin
				if (srst) begin
					meta <= 1'b0;
					sync <= 1'b0;
				end else begin
					meta <= lvlRaw[gi];
					sync <= meta;
				end
			end
			assign lvlSync[gi] = sync;
		end
	endgenerate

	// Bus decode
	rsc_pkg::rsc_sel_t sel;
	logic              setupPh;
	logic              accessPh;
	logic              wrDone;
	logic              cauWr;
	logic [7:0]        wrByte;
	logic [31:0]       readMux;

	assign sel      = rscDecode(paddr);
	assign setupPh  = psel && !penable;
	assign accessPh = psel && penable && pready;
	assign wrDone   = accessPh && pwrite && pstrb[0] && (sel != rsc_pkg::SEL_NONE);
	assign cauWr    = wrDone && (sel == rsc_pkg::SEL_CAUSE);
	assign wrByte   = pwdata[7:0];

	logic [2:0] ctrl;

	always_comb begin
		case (sel)
			rsc_pkg::SEL_CAUSE: readMux = {24'h00_0000, cif.flags}; // R1
			rsc_pkg::SEL_CTRL:  readMux = {29'h0000_0000, ctrl};
			default:            readMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setupPh;
			pslverr <= setupPh && (sel == rsc_pkg::SEL_NONE);
			if (setupPh && !pwrite) begin
				prdata <= readMux;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl <= rsc_pkg::CTRL_RESET;
		end else if (wrDone && (sel == rsc_pkg::SEL_CTRL)) begin
			ctrl <= wrByte[2:0];
		end
	end

	// Watchdog service sequence
	logic              isFirst;
	logic              isSecond;
	logic              badSvc;
	logic              dbgPulse;
	rsc_pkg::rsc_svc_t svcState;

	assign isFirst  = wrByte == rsc_pkg::SVC_FIRST;
	assign isSecond = wrByte == rsc_pkg::SVC_SECOND;
	assign badSvc   = cauWr && ctrl[rsc_pkg::CTRL_WDOG_EN] && !isFirst && !isSecond; // R3
	assign dbgPulse = wrDone && (sel == rsc_pkg::SEL_DBG) && wrByte[rsc_pkg::DBG_FORCE]; // R2

	always_ff @(posedge clk) begin
		if (srst) begin
			svcState <= rsc_pkg::SVC_IDLE;
		end else if (cif.entry) begin
			svcState <= rsc_pkg::SVC_IDLE;
		end else if (cauWr) begin
			case (svcState)
				rsc_pkg::SVC_IDLE: begin
					if (isFirst) begin
						svcState <= rsc_pkg::SVC_ARMED; // R4
					end
				end
				rsc_pkg::SVC_ARMED: begin
					svcState <= isFirst ? rsc_pkg::SVC_ARMED : rsc_pkg::SVC_IDLE;
				end
				default: svcState <= rsc_pkg::SVC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wdRestart <= 1'b0;
		end else begin
			wdRestart <= cauWr && isSecond && (svcState == rsc_pkg::SVC_ARMED); // R4
		end
	end

	// Reset sources and entry
	logic evWdog;
	logic evOpc;
	logic lvlActive;
	logic anySrc;

	assign evWdog    = (wdTimeout && ctrl[rsc_pkg::CTRL_WDOG_EN]) || badSvc; // R8
	assign evOpc     = illegalOpcode
		|| (haltInstr && !ctrl[rsc_pkg::CTRL_HALT_EN])
		|| (bgndInstr && !ctrl[rsc_pkg::CTRL_BACKGROUND_ENTRY_INSTRUCTION_EN]); // R9
	assign lvlActive = |lvlSync;
	assign anySrc    = lvlActive || evWdog || evOpc || illegalAddress || dbgPulse;

	assign cif.srcPor  = lvlSync[rsc_pkg::LVL_POR]; // R5
	assign cif.srcLvd  = lvlSync[rsc_pkg::LVL_LVD]; // R11
	assign cif.srcLoc  = lvlSync[rsc_pkg::LVL_LOC];
	assign cif.srcPin  = lvlSync[rsc_pkg::LVL_PIN]; // R7
	assign cif.srcWdog = evWdog;
	assign cif.srcOpc  = evOpc;
	assign cif.srcAdr  = illegalAddress; // R10
	assign cif.srcDbg  = dbgPulse;
	assign cif.entry   = anySrc && !mcuResetReq; // R6

	// Reset request: held a minimum time, then until level sources release
	logic [rsc_pkg::HOLD_W-1:0] holdCnt;

	always_ff @(posedge clk) begin
		if (srst) begin
			mcuResetReq <= 1'b0;
			holdCnt     <= '0;
		end else if (cif.entry) begin
			mcuResetReq <= 1'b1;
			holdCnt     <= HOLD;
		end else if (mcuResetReq) begin
			if (holdCnt != '0) begin
				holdCnt <= holdCnt - rsc_pkg::HOLD_W'(1);
			end else if (!lvlActive) begin
				mcuResetReq <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Cycles the reset request has stood since entry, saturating
	logic [rsc_pkg::HOLD_W-1:0] reqAge;

	always_ff @(posedge clk) begin
		if (srst) begin
			reqAge <= '0;
		end else if (cif.entry) begin
			reqAge <= '0;
		end else if (mcuResetReq && (reqAge != '1)) begin
			reqAge <= reqAge + rsc_pkg::HOLD_W'(1);
		end
	end

	sequence sQuietOthers;
		!cif.srcPor && !cif.srcLvd && !dbgPulse;
	endsequence

	sequence sFirstWr;
		cauWr && wrByte == rsc_pkg::SVC_FIRST && !cif.entry;
	endsequence

	sequence sSecondWr;
		cauWr && wrByte == rsc_pkg::SVC_SECOND;
	endsequence

	sequence sSetupRead;
		psel && !penable && !pwrite;
	endsequence

	sequence sDbgForceWr;
		psel && penable && pready && pwrite && pstrb[0] && paddr == rsc_pkg::OFS_DBG
		&& pwdata[rsc_pkg::DBG_FORCE];
	endsequence

	a_bad_write_reset: assert property ( // R3
		!mcuResetReq && cauWr && ctrl[rsc_pkg::CTRL_WDOG_EN]
		&& wrByte != rsc_pkg::SVC_FIRST && wrByte != rsc_pkg::SVC_SECOND
		&& !cif.srcPor && !cif.srcLvd |=> mcuResetReq && cif.flags[rsc_pkg::BIT_WDOG])
		else $error("bad service value did not cause watchdog reset");
	a_service_restart: assert property ( // R4
		sFirstWr ##1 !cif.entry ##1 sSecondWr |=> wdRestart)
		else $error("service pair did not restart watchdog");
	a_service_no_flags: assert property ( // R4
		cauWr && (isFirst || isSecond) && !cif.entry |=> $stable(cif.flags))
		else $error("service write changed cause flags");
	a_timeout_blocked: assert property ( // R8
		!mcuResetReq && wdTimeout && !ctrl[rsc_pkg::CTRL_WDOG_EN] && !lvlActive && !cauWr
		&& !wrDone && !evOpc && !illegalAddress |=> !mcuResetReq)
		else $error("timeout reset while watchdog disabled");
	a_halt_illegal: assert property ( // R9
		(!mcuResetReq && haltInstr && !ctrl[rsc_pkg::CTRL_HALT_EN]) and sQuietOthers
		|=> mcuResetReq && cif.flags[rsc_pkg::BIT_OPC])
		else $error("disabled halt instruction not treated as illegal");
	a_background_entry_instruction_illegal: assert property ( // R9
		(!mcuResetReq && bgndInstr && !ctrl[rsc_pkg::CTRL_BACKGROUND_ENTRY_INSTRUCTION_EN]) and sQuietOthers
		|=> mcuResetReq && cif.flags[rsc_pkg::BIT_OPC])
		else $error("disabled background entry not treated as illegal");
	a_timeout_flag: assert property ( // R8
		(!mcuResetReq && wdTimeout && ctrl[rsc_pkg::CTRL_WDOG_EN]) and sQuietOthers
		|=> mcuResetReq && cif.flags[rsc_pkg::BIT_WDOG])
		else $error("enabled timeout did not set watchdog flag");
	a_pin_flag: assert property ( // R7
		(!mcuResetReq && cif.srcPin) and sQuietOthers
		|=> mcuResetReq && cif.flags[rsc_pkg::BIT_PIN])
		else $error("external pin reset did not set pin flag");
	a_address_flag: assert property ( // R10
		(!mcuResetReq && illegalAddress) and sQuietOthers
		|=> mcuResetReq && cif.flags[rsc_pkg::BIT_ADR])
		else $error("illegal address did not set address flag");
	a_debug_force: assert property ( // R2
		(!mcuResetReq && !cif.srcPor && !cif.srcLvd) and sDbgForceWr
		|=> mcuResetReq && cif.flags == rsc_pkg::FLAGS_NONE)
		else $error("debug forced reset did not clear flags");
	a_flags_frozen: assert property ( // R1
		mcuResetReq |=> $stable(cif.flags))
		else $error("cause flags changed while reset requested");
	a_restart_cause: assert property ( // R4
		wdRestart |-> $past(svcState) == rsc_pkg::SVC_ARMED && $past(cauWr))
		else $error("watchdog restart without armed sequence");
	a_restart_pulse: assert property (wdRestart |=> !wdRestart) // R4
		else $error("watchdog restart longer than one cycle");
	a_lone_second: assert property ( // R4
		(svcState == rsc_pkg::SVC_IDLE) and sSecondWr |=> !wdRestart)
		else $error("second service value alone restarted watchdog");
	a_req_min_hold: assert property ($fell(mcuResetReq) |-> reqAge >= HOLD)
		else $error("reset request released before minimum hold");
	a_req_levels: assert property (mcuResetReq && lvlActive |=> mcuResetReq)
		else $error("reset request released while a level source is active");
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready in the cycle after setup");
	a_ready_only_setup: assert property (!(psel && !penable) |=> !pready)
		else $error("ready without a preceding setup");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error response without ready");
	a_unmapped_err: assert property (
		psel && !penable && paddr != rsc_pkg::OFS_CAUSE && paddr != rsc_pkg::OFS_CTRL
		&& paddr != rsc_pkg::OFS_DBG |=> pslverr)
		else $error("unmapped address without error response");
	a_read_cause: assert property ( // R1
		(paddr == rsc_pkg::OFS_CAUSE) and sSetupRead
		|=> prdata == {24'h00_0000, $past(cif.flags)})
		else $error("cause read data differs from flags");
	a_read_held: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed outside a read setup");
	a_ctrl_write: assert property (
		psel && penable && pready && pwrite && pstrb[0] && paddr == rsc_pkg::OFS_CTRL
		|=> ctrl == $past(pwdata[rsc_pkg::CTRL_BACKGROUND_ENTRY_INSTRUCTION_EN:0]))
		else $error("control write did not land");
endmodule : rsc_top

// ### include/rsc_pkg.sv
// Constants and types for the reset cause and watchdog service block
//
// Overview of operation
// R1: An 8-bit read-only cause register holds one flag per reset source, refreshed at reset entry.
// R2: A reset forced through the debug force-reset bit leaves every cause flag cleared.
// R3: With the watchdog enabled, a cause-register write of any value but the two service values resets at once.
// R4: Writing the first then the second service value restarts the watchdog and leaves the flags alone.
// R5: Power-on reset sets the power-on flag in bit 7 and the undervoltage flag, and clears the rest.
// R6: Any other reset sets each pin, watchdog, opcode and address flag whose source is active at entry.
// R7: The external line flag in bit 6 marks a reset from a low level on the external reset pin.
// R8: The watchdog flag in bit 5 marks a timeout reset, and no timeout reset occurs while disabled.
// R9: The opcode flag in bit 4 marks an illegal opcode, counting halt or background entry when disabled.
// R10: The address flag in bit 3 marks a reset after access to an unimplemented address.
// R11: Low-voltage reset keeps the power-on flag, sets bit 1, clears the others, and bit 0 reads zero.
package rsc_pkg;
	localparam int          ADDR_W     = 12;
	localparam logic [11:0] OFS_CAUSE  = 12'h000;
	localparam logic [11:0] OFS_CTRL   = 12'h004;
	localparam logic [11:0] OFS_DBG    = 12'h008;

	localparam int          BIT_POR    = 7;
	localparam int          BIT_PIN    = 6;
	localparam int          BIT_WDOG   = 5;
	localparam int          BIT_OPC    = 4;
	localparam int          BIT_ADR    = 3;
	localparam int          BIT_LOC    = 2;
	localparam int          BIT_LVD    = 1;
	localparam int          BIT_ZERO   = 0;
	localparam logic [7:0]  FLAGS_POR  = 8'h82;
	localparam logic [7:0]  FLAGS_NONE = 8'h00;

	localparam logic [7:0]  SVC_FIRST  = 8'h55;
	localparam logic [7:0]  SVC_SECOND = 8'hAA;

	localparam int          CTRL_WDOG_EN = 0;
	localparam int          CTRL_HALT_EN = 1;
	localparam int          CTRL_BACKGROUND_ENTRY_INSTRUCTION_EN = 2;
	localparam logic [2:0]  CTRL_RESET   = 3'h1;
	localparam int          DBG_FORCE    = 0;

	localparam int          NLVL     = 4;
	localparam int          LVL_POR  = 3;
	localparam int          LVL_LVD  = 2;
	localparam int          LVL_LOC  = 1;
	localparam int          LVL_PIN  = 0;

	localparam int          HOLD_W     = 8;
	localparam int          RESET_HOLD = 16;

	typedef enum logic {SVC_IDLE, SVC_ARMED} rsc_svc_t;
	typedef enum logic [1:0] {SEL_NONE, SEL_CAUSE, SEL_CTRL, SEL_DBG} rsc_sel_t;
endpackage : rsc_pkg

// ### include/rsc_cause_if.sv
// Interface carrying reset sources and cause flags between controller and capture
`timescale 1ns/1ps
interface rsc_cause_if;
	logic       entry;
	logic       srcPor;
	logic       srcLvd;
	logic       srcDbg;
	logic       srcPin;
	logic       srcWdog;
	logic       srcOpc;
	logic       srcAdr;
	logic       srcLoc;
	logic [7:0] flags;

	modport ctrl (output entry, srcPor, srcLvd, srcDbg, srcPin, srcWdog, srcOpc, srcAdr,
		srcLoc, input flags);
	modport cap (input entry, srcPor, srcLvd, srcDbg, srcPin, srcWdog, srcOpc, srcAdr,
		srcLoc, output flags);
endinterface : rsc_cause_if

// ### core/rsc_cause_capture.sv
// Cause flag register loaded at reset entry
`timescale 1ns/1ps
module rsc_cause_capture (
	input wire logic  clk,
	input wire logic  srst,
	rsc_cause_if.cap  cif
);
	logic [7:0] flagReg;

	assign cif.flags = flagReg;

	always_ff @(posedge clk) begin
		if (srst) begin
			flagReg <= rsc_pkg::FLAGS_POR;
		end else if (cif.entry) begin
			if (cif.srcPor) begin
				flagReg <= rsc_pkg::FLAGS_POR; // R5
			end else if (cif.srcLvd) begin
				flagReg                   <= rsc_pkg::FLAGS_NONE; // R11
				flagReg[rsc_pkg::BIT_POR] <= flagReg[rsc_pkg::BIT_POR]; // R11
				flagReg[rsc_pkg::BIT_LVD] <= 1'b1; // R11
			end else if (cif.srcDbg) begin
				flagReg <= rsc_pkg::FLAGS_NONE; // R2
			end else begin
				flagReg                    <= rsc_pkg::FLAGS_NONE; // R6
				flagReg[rsc_pkg::BIT_PIN]  <= cif.srcPin; // R7
				flagReg[rsc_pkg::BIT_WDOG] <= cif.srcWdog; // R8
				flagReg[rsc_pkg::BIT_OPC]  <= cif.srcOpc; // R9
				flagReg[rsc_pkg::BIT_ADR]  <= cif.srcAdr; // R10
				flagReg[rsc_pkg::BIT_LOC]  <= cif.srcLoc;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence sOtherEntry;
		cif.entry && !cif.srcPor && !cif.srcLvd && !cif.srcDbg;
	endsequence

	a_por_pattern: assert property (cif.entry && cif.srcPor |=> flagReg == 8'h82) // R5
		else $error("power-on entry did not load power-on pattern");
	a_lvd_keeps_por: assert property ( // R11
		cif.entry && !cif.srcPor && cif.srcLvd |=>
		flagReg[7] == $past(flagReg[7]) && flagReg[6:0] == 7'h02)
		else $error("low-voltage entry flags wrong");
	a_debug_clears: assert property ( // R2
		cif.entry && !cif.srcPor && !cif.srcLvd && cif.srcDbg |=> flagReg == 8'h00)
		else $error("debug forced reset left flags set");
	a_source_flags: assert property ( // R6 R7 R8 R9 R10
		sOtherEntry |=> flagReg[7:3] == {1'b0, $past(cif.srcPin), $past(cif.srcWdog),
		$past(cif.srcOpc), $past(cif.srcAdr)} && flagReg[1:0] == 2'b00)
		else $error("source flags do not match active sources");
	a_bit0_zero: assert property (flagReg[0] == 1'b0) // R11
		else $error("bit 0 of cause register set");
	a_flags_hold: assert property (!cif.entry |=> $stable(flagReg)) // R1
		else $error("cause flags changed outside reset entry");
endmodule : rsc_cause_capture

// ### verif/tb.sv
// Self-checking testbench for the reset cause and watchdog service block
`timescale 1ns/1ps
module tb;
	logic                       clk = 1'b0;
	logic                       srst = 1'b1;
	logic                       psel = 1'b0;
	logic                       penable = 1'b0;
	logic                       pwrite = 1'b0;
	logic [rsc_pkg::ADDR_W-1:0] paddr = 12'h000;
	logic [31:0]                pwdata = 32'h0000_0000;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	logic [8:0]                 src = 9'h000;
	logic                       mcuResetReq;
	logic                       wdRestart;
	logic [31:0]                rd;
	logic                       err;
	int                         failures = 0;
	int                         checksDone = 0;
	int                         cycles = 0;

	rsc_top #(.RESET_HOLD_CYCLES(2)) uut (
		.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .powerOnDetect(src[0]), .lowVoltDetect(src[1]),
		.referenceLost(src[2]), .extResetN(~src[3]), .wdTimeout(src[4]),
		.illegalOpcode(src[5]), .illegalAddress(src[6]), .haltInstr(src[7]),
		.bgndInstr(src[8]), .mcuResetReq(mcuResetReq), .wdRestart(wdRestart)
	);

	always #50 clk = ~clk;

	// Hang guard: whole run needs a few hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures = failures + 1;
			finish_test();
		end
	end

	task finish_test();
		$display("checks %0d failures %0d", checksDone, failures);
		if (failures == 0 && checksDone > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checksDone = checksDone + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Waits out the access phase until pready is seen high at a rising edge
	task waitReady();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk({31'h0, pready}, 32'h1, "pready");
	endtask : waitReady

	// One APB transfer; holds the request until pready is seen high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		waitReady();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Service pair back to back: second setup follows the first access at once
	task svcPair();
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= 1'b1;
		paddr <= rsc_pkg::OFS_CAUSE;
		pwdata <= 32'h0000_0055;
		@(posedge clk);
		penable <= 1'b1;
		waitReady();
		penable <= 1'b0;
		pwdata <= 32'h0000_00AA;
		@(posedge clk);
		penable <= 1'b1;
		waitReady();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : svcPair

	task waitReq(input logic v);
		int n;
		n = 0;
		while (mcuResetReq !== v && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, mcuResetReq}, {31'h0, v}, "reset request");
	endtask : waitReq

	// Reset entry, release of all sources, exit, then cause readback
	task resetSeen(input logic [7:0] exp);
		waitReq(1'b1);
		src <= 9'h000;
		waitReq(1'b0);
		apb(1'b0, rsc_pkg::OFS_CAUSE, 32'h0);
		chk(rd, {24'h0, exp}, "cause flags");
	endtask : resetSeen

	task fire(input int b, input logic [7:0] exp);
		@(posedge clk);
		src[b] <= 1'b1;
		resetSeen(exp);
	endtask : fire

	task test_reset();
		apb(1'b0, rsc_pkg::OFS_CAUSE, 32'h0);
		chk(rd, 32'h0000_0082, "cause after reset");
		apb(1'b0, rsc_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0000_0001, "ctrl after reset");
		chk({31'h0, err}, 32'h0, "mapped read without error");
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		$display("test reset done");
	endtask : test_reset

	task test_sources();
		fire(1, 8'h82);
		fire(5, 8'h10);
		fire(6, 8'h08);
		fire(3, 8'h40);
		fire(2, 8'h04);
		fire(4, 8'h20);
		fire(7, 8'h10);
		fire(8, 8'h10);
		fire(1, 8'h02);
		fire(0, 8'h82);
		$display("test sources done");
	endtask : test_sources

	task test_service();
		logic seen;
		seen = 1'b0;
		apb(1'b1, rsc_pkg::OFS_CAUSE, 32'h0000_0055);
		apb(1'b1, rsc_pkg::OFS_CAUSE, 32'h0000_00AA);
		repeat (3) begin
			@(posedge clk);
			if (wdRestart === 1'b1) seen = 1'b1;
		end
		chk({31'h0, seen}, 32'h1, "restart pulse");
		chk({31'h0, mcuResetReq}, 32'h0, "no reset on service");
		seen = 1'b0;
		svcPair();
		repeat (3) begin
			@(posedge clk);
			if (wdRestart === 1'b1) seen = 1'b1;
		end
		chk({31'h0, seen}, 32'h1, "back-to-back restart");
		chk({31'h0, mcuResetReq}, 32'h0, "no reset on back-to-back service");
		apb(1'b0, rsc_pkg::OFS_CAUSE, 32'h0);
		chk(rd, 32'h0000_0082, "flags kept");
		$display("test service done");
	endtask : test_service

	task test_bad_write();
		apb(1'b1, rsc_pkg::OFS_CAUSE, 32'h0000_00AA);
		repeat (4) @(posedge clk);
		chk({31'h0, mcuResetReq}, 32'h0, "lone second value");
		apb(1'b1, rsc_pkg::OFS_CAUSE, 32'h0000_0012);
		resetSeen(8'h20);
		$display("test bad write done");
	endtask : test_bad_write

	task test_disabled();
		apb(1'b1, rsc_pkg::OFS_CTRL, 32'h0);
		@(posedge clk);
		src[4] <= 1'b1;
		repeat (8) @(posedge clk);
		src[4] <= 1'b0;
		chk({31'h0, mcuResetReq}, 32'h0, "timeout while disabled");
		apb(1'b1, rsc_pkg::OFS_CAUSE, 32'h0000_0033);
		repeat (5) @(posedge clk);
		chk({31'h0, mcuResetReq}, 32'h0, "bad write while disabled");
		apb(1'b1, rsc_pkg::OFS_CTRL, 32'h0000_0006);
		@(posedge clk);
		src[8:7] <= 2'b11;
		@(posedge clk);
		src[8:7] <= 2'b00;
		repeat (4) @(posedge clk);
		chk({31'h0, mcuResetReq}, 32'h0, "enabled halt or background");
		apb(1'b1, rsc_pkg::OFS_CTRL, 32'h0000_0001);
		$display("test disabled done");
	endtask : test_disabled

	task test_debug();
		apb(1'b1, rsc_pkg::OFS_DBG, 32'h0000_0001);
		resetSeen(8'h00);
		$display("test debug done");
	endtask : test_debug

	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		test_reset();
		test_service();
		test_sources();
		test_bad_write();
		test_disabled();
		test_debug();
		finish_test();
	end
endmodule : tb
